// ---- hw/tlvi_pkg.sv ----
// package for the two-level vectored interrupt unit
package tlvi_pkg;
    localparam int NSRC = 9;
    localparam int PC_W = 16;
    // source index equals polling rank, 0 polled first
    localparam int SRC_PSM  = 0;
    localparam int SRC_EX0  = 1;
    localparam int SRC_ADC  = 2;
    localparam int SRC_TM0  = 3;
    localparam int SRC_EX1  = 4;
    localparam int SRC_TM1  = 5;
    localparam int SRC_TWI  = 6;
    localparam int SRC_SER  = 7;
    localparam int SRC_TM2  = 8;
    localparam logic [PC_W-1:0] VEC_EX0 = 16'h0003;
    localparam logic [PC_W-1:0] VEC_TM0 = 16'h000B;
    localparam logic [PC_W-1:0] VEC_EX1 = 16'h0013;
    localparam logic [PC_W-1:0] VEC_TM1 = 16'h001B;
    localparam logic [PC_W-1:0] VEC_SER = 16'h0023;
    localparam logic [PC_W-1:0] VEC_TM2 = 16'h002B;
    localparam logic [PC_W-1:0] VEC_ADC = 16'h0033;
    localparam logic [PC_W-1:0] VEC_TWI = 16'h003B;
    localparam logic [PC_W-1:0] VEC_PSM = 16'h0043;
    localparam logic [PC_W-1:0] PC_RST  = 16'h0000;
    typedef enum logic [1:0] {TLVI_IDLE, TLVI_PUSH, TLVI_LOAD} tlvi_state_t;
endpackage : tlvi_pkg

// ---- hw/tlvi_pick.sv ----
// fixed-order picker: lowest index among the request bits wins
`timescale 1ns/10ps
`default_nettype none
module tlvi_pick #(
    parameter int N = 9
) (
    input  wire logic [N-1:0]         req,
    output logic                      any,
    output logic [$clog2(N)-1:0]      idx
);
    // scan from the highest rank downward so the last hit, the lowest index and highest priority, wins
    always_comb begin
        any = 1'b0;
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                any = 1'b1;
                idx = i[$clog2(N)-1:0];
            end
        end
    end
endmodule : tlvi_pick
`default_nettype wire

// ---- hw/tlvi_top.sv ----
// two-level vectored interrupt unit: arbitration, nesting and vectoring
`timescale 1ns/10ps
`default_nettype none
module tlvi_top (
    // clock and synchronous reset
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    // peripheral flags, level high, from logic on this clock
    input  wire logic                      supply_monitor_request,
    input  wire logic                      external_zero_request,
    input  wire logic                      converter_done_request,
    input  wire logic                      timer_zero_overflow_flag,
    input  wire logic                      external_one_request,
    input  wire logic                      timer_one_overflow_flag,
    input  wire logic                      two_wire_request,
    input  wire logic                      serial_peripheral_request,
    input  wire logic                      serial_receive_flag,
    input  wire logic                      serial_transmit_flag,
    input  wire logic                      timer_two_overflow_flag,
    input  wire logic                      timer_two_external_flag,
    // software controls; bit index is the polling rank
    input  wire logic                      global_interrupt_enable,
    input  wire logic [tlvi_pkg::NSRC-1:0] source_enable,
    input  wire logic [tlvi_pkg::NSRC-1:0] source_priority_high,
    // core side: return address, readiness, end of routine
    input  wire logic [tlvi_pkg::PC_W-1:0] core_pc,
    input  wire logic                      core_ready,
    input  wire logic                      return_done,
    // vectoring handshake toward the core
    output logic                           push_valid,
    output logic [tlvi_pkg::PC_W-1:0]      push_pc,
    output logic                           load_valid,
    output logic [tlvi_pkg::PC_W-1:0]      load_vector,
    output logic [tlvi_pkg::NSRC-1:0]      ack_source,
    // nesting state, visible to software
    output logic                           in_low_service,
    output logic                           in_high_service
);
    import tlvi_pkg::*;

    // picker index width
    localparam int IW = $clog2(NSRC);

    // sequencer and nesting registers
    tlvi_state_t         state_r;
    tlvi_state_t         state_nxt;
    logic                low_act_r;
    logic                low_act_nxt;
    logic                high_act_r;
    logic                high_act_nxt;
    // values captured at acceptance, held until the next one
    logic [PC_W-1:0]     push_pc_r;
    logic [PC_W-1:0]     push_pc_nxt;
    logic [PC_W-1:0]     vec_r;
    logic [PC_W-1:0]     vec_nxt;
    logic [IW-1:0]       sel_r;
    logic [IW-1:0]       sel_nxt;
    logic                high_sel_r;
    logic                high_sel_nxt;
    // acknowledge register, one bit per polling rank
    logic [NSRC-1:0]     ack_r;
    logic [NSRC-1:0]     ack_nxt;

    // shared vectors combine their flags into one request
    wire logic [NSRC-1:0] raw_req = {
        timer_two_overflow_flag | timer_two_external_flag,
        serial_receive_flag | serial_transmit_flag,
        two_wire_request | serial_peripheral_request,
        timer_one_overflow_flag,
        external_one_request,
        timer_zero_overflow_flag,
        converter_done_request,
        external_zero_request,
        supply_monitor_request};

    // global then per-source gating, split by level
    wire logic [NSRC-1:0] en_req =
        raw_req & source_enable & {NSRC{global_interrupt_enable}};
    wire logic [NSRC-1:0] hi_req = en_req & source_priority_high;
    wire logic [NSRC-1:0] lo_req = en_req & ~source_priority_high;

    // picker results per level
    wire logic          hi_any, lo_any;
    wire logic [IW-1:0] hi_idx, lo_idx;

    // one picker per level, each keeps the polling order
    tlvi_pick #(.N(NSRC)) u_pick_hi (
        .req (hi_req),
        .any (hi_any),
        .idx (hi_idx)
    );
    tlvi_pick #(.N(NSRC)) u_pick_lo (
        .req (lo_req),
        .any (lo_any),
        .idx (lo_idx)
    );

    // vector lookup by source rank
    function automatic logic [PC_W-1:0] vec_of(input logic [IW-1:0] s);
        case (s)
            IW'(SRC_PSM): vec_of = VEC_PSM;
            IW'(SRC_EX0): vec_of = VEC_EX0;
            IW'(SRC_ADC): vec_of = VEC_ADC;
            IW'(SRC_TM0): vec_of = VEC_TM0;
            IW'(SRC_EX1): vec_of = VEC_EX1;
            IW'(SRC_TM1): vec_of = VEC_TM1;
            IW'(SRC_TWI): vec_of = VEC_TWI;
            IW'(SRC_SER): vec_of = VEC_SER;
            IW'(SRC_TM2): vec_of = VEC_TM2;
            // ranks past the last source cannot occur
            default:      vec_of = PC_RST;
        endcase
    endfunction : vec_of

    // state decode, shared by acceptance and the strobes
    function automatic logic st_is(input tlvi_state_t s,
                                   input tlvi_state_t want);
        st_is = (s == want);
    endfunction : st_is

    // a level is blocked while a routine of that level or above runs;
    // a blocked request is not dropped, it waits for the return
    wire logic hi_blocked = high_act_r;
    wire logic lo_blocked = low_act_r || high_act_r;

    // high wins whenever allowed; nothing preempts a high routine and a
    // low request never preempts a low routine
    wire logic take_hi = hi_any && !hi_blocked;
    wire logic take_lo = lo_any && !lo_blocked
                         && !hi_any;
    // the core gates acceptance while it cannot take an interrupt; the
    // sequencer must be idle, so accepts are at least three cycles apart
    wire logic is_idle = st_is(state_r, TLVI_IDLE);
    wire logic accept  = is_idle && core_ready
                         && (take_hi || take_lo);
    // the picked source stays fixed from here until the load
    wire logic [IW-1:0] pick_idx = take_hi ? hi_idx : lo_idx;

    // push first, load the vector next
    // each accept costs three cycles: push, load, back to idle
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            TLVI_IDLE: if (accept) state_nxt = TLVI_PUSH;
            TLVI_PUSH: state_nxt = TLVI_LOAD;
            TLVI_LOAD: state_nxt = TLVI_IDLE;
        endcase
    end

    // strobes are plain decodes of the state register
    assign push_valid  = st_is(state_r, TLVI_PUSH);
    assign load_valid  = st_is(state_r, TLVI_LOAD);
    // data outputs straight from their registers
    assign push_pc     = push_pc_r;
    assign load_vector = vec_r;
    assign ack_source  = ack_r;
    assign in_low_service  = low_act_r;
    assign in_high_service = high_act_r;

    // one-hot acknowledge so the core can clear the served flag; it is
    // formed during the push so that it stands exactly with the load
    genvar g;
    for (g = 0; g < NSRC; g++) begin : g_ack
        assign ack_nxt[g] = push_valid && (sel_r == IW'(g));
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ack_r <= '0;
        end else begin
            ack_r <= ack_nxt;
        end
    end

    // sequencer register; reset parks it idle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= TLVI_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // capture return address, vector and level at acceptance; the
    // registers hold otherwise so the core may read them late
    assign push_pc_nxt  = accept ? core_pc : push_pc_r;
    assign vec_nxt      = accept ? vec_of(pick_idx) : vec_r;
    assign sel_nxt      = accept ? pick_idx : sel_r;
    assign high_sel_nxt = accept ? take_hi : high_sel_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            push_pc_r  <= PC_RST;
            vec_r      <= PC_RST;
            sel_r      <= '0;
            high_sel_r <= 1'b0;
        end else begin
            push_pc_r  <= push_pc_nxt;
            vec_r      <= vec_nxt;
            sel_r      <= sel_nxt;
            high_sel_r <= high_sel_nxt;
        end
    end

    // nesting: a return ends the innermost routine, high before low;
    // activity starts at the load so a return cannot race the entry;
    // a load beats a return in the same cycle, so the core must not
    // return while it is being vectored
    wire logic ret_hi = return_done && high_act_r;
    wire logic ret_lo = return_done && !high_act_r;
    assign high_act_nxt = load_valid ? (high_act_r || high_sel_r)
                                     : (high_act_r && !ret_hi);
    assign low_act_nxt  = load_valid ? (low_act_r || !high_sel_r)
                                     : (low_act_r && !ret_lo);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            low_act_r  <= 1'b0;
            high_act_r <= 1'b0;
        end else begin
            low_act_r  <= low_act_nxt;
            high_act_r <= high_act_nxt;
        end
    end
endmodule : tlvi_top
`default_nettype wire

// ---- tb/tlvi_asserts.sv ----
// assertions on the interrupt unit ports
`timescale 1ns/10ps
`default_nettype none
module tlvi_asserts (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        global_interrupt_enable,
    input wire logic [15:0] core_pc,
    input wire logic        push_valid,
    input wire logic [15:0] push_pc,
    input wire logic        load_valid,
    input wire logic [15:0] load_vector,
    input wire logic [8:0]  ack_source,
    input wire logic        in_high_service
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    push_load_a: assert property (push_valid |=> load_valid && !push_valid)
        else $error("no load after push");
    push_pc_a: assert property (push_valid |-> push_pc == $past(core_pc))
        else $error("wrong pushed pc");
    ack_one_a: assert property (load_valid |-> $onehot(ack_source))
        else $error("ack not one-hot");
    vec_ext0_a: assert property (ack_source[1] |-> load_vector == 16'h0003)
        else $error("bad vector");
    vec_tmr1_a: assert property (ack_source[5] |-> load_vector == 16'h001B)
        else $error("bad vector");
    vec_supply_a: assert property (ack_source[0] |-> load_vector == 16'h0043)
        else $error("bad vector");
    gate_off_a: assert property (!global_interrupt_enable |=> !push_valid)
        else $error("accepted while gated");
    high_hold_a: assert property (in_high_service && $past(in_high_service)
        |-> !push_valid) else $error("high routine preempted");
endmodule : tlvi_asserts
bind tlvi_top tlvi_asserts i_chk (.*);
`default_nettype wire

// ---- tb/tlvi_core_model.sv ----
// core stand-in: program counter, return stack, return pulses
`timescale 1ns/10ps
`default_nettype none
module tlvi_core_model (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        push_valid,
    input wire logic [15:0] push_pc,
    input wire logic        load_valid,
    input wire logic [15:0] load_vector,
    input wire logic        ret_cmd,
    input wire logic        stall,
    output logic [15:0]     core_pc,
    output logic            core_ready,
    output logic            return_done
);
    logic [15:0] stk [$];
    // a stalled core is slow to take an interrupt
    assign core_ready = !stall;
    // pc runs on; push saves, load jumps, return pops
    always @(posedge clk) begin
        return_done <= 1'b0;
        if (sys_rst) begin
            core_pc <= 16'h0100;
            stk.delete();
        end else if (load_valid) core_pc <= load_vector;
        else if (ret_cmd && stk.size() > 0) begin
            core_pc <= stk.pop_back();
            return_done <= 1'b1;
        end else core_pc <= core_pc + 16'h1;
        if (push_valid) stk.push_back(push_pc);
    end
endmodule : tlvi_core_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the interrupt unit
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk = 0, sys_rst = 1, global_interrupt_enable = 0, ret_cmd = 0;
    logic stall = 0, core_ready, return_done, push_valid, load_valid;
    logic in_low_service, in_high_service;
    logic [11:0] fl = '0;
    logic [8:0] source_enable = '1, source_priority_high = '0, ack_source;
    logic [15:0] core_pc, push_pc, load_vector, lfsr = 16'h000E;
    int err_count = 0, checks_done = 0, k;
    // vector per polling rank
    localparam logic [15:0] VT [9] = '{16'h0043, 16'h0003, 16'h0033,
        16'h000B, 16'h0013, 16'h001B, 16'h003B, 16'h0023, 16'h002B};
    // next value of the stimulus shift register
    function automatic logic [15:0] lfsr_step(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_step
    // one-hot acknowledge expected for a polling rank
    function automatic logic [15:0] exp_ack(input int r);
        return 16'h1 << r;
    endfunction : exp_ack
    tlvi_top i_dut (.*, .supply_monitor_request(fl[0]),
        .external_zero_request(fl[1]), .converter_done_request(fl[2]),
        .timer_zero_overflow_flag(fl[3]), .external_one_request(fl[4]),
        .timer_one_overflow_flag(fl[5]), .two_wire_request(fl[6]),
        .serial_peripheral_request(fl[7]), .serial_receive_flag(fl[8]),
        .serial_transmit_flag(fl[9]), .timer_two_overflow_flag(fl[10]),
        .timer_two_external_flag(fl[11]));
    tlvi_core_model i_core (.*);
    initial forever #25 clk = ~clk;
    task automatic chk(logic [15:0] seen, logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic complete_run();
        $display("mismatches %0d, checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : complete_run
    // bounded wait for a load; rank -1 means none may come
    task automatic take(int r);
        int i;
        for (i = 0; i < 40 && load_valid !== 1'b1; i++) begin
            @(negedge clk);
            stall = lfsr[1];
            lfsr = lfsr_step(lfsr);
        end
        if (r < 0) chk(16'(load_valid), 16'h0);
        else if (i == 40) begin
            err_count++;
            complete_run();
        end else begin
            chk(load_vector, VT[r]);
            chk(16'(ack_source), exp_ack(r));
        end
        @(negedge clk);
    endtask : take
    task automatic ret();
        ret_cmd = 1;
        @(negedge clk);
        ret_cmd = 0;
        repeat (2) @(negedge clk);
    endtask : ret
    initial begin
        repeat (10) @(negedge clk);
        sys_rst = 0;
        global_interrupt_enable = 1;
        // each rank against random later-polled ranks; shared flags picked at random
        for (k = 0; k < 9; k++) begin
            fl = 12'h1 << (k < 6 ? k : 2 * k - 6 + int'(lfsr[0]));
            fl = fl | (12'(lfsr) & ~((fl << 1) - 12'h1));
            take(k);
            chk(16'({in_high_service, in_low_service}), 16'h1);
            fl = '0;
            ret();
        end
        source_priority_high = 9'h102;
        fl = 12'h801;
        take(8);
        chk(16'({in_high_service, in_low_service}), 16'h2);
        fl = 12'h003;
        take(-1);
        ret();
        take(1);
        fl = 12'h001;
        ret();
        take(0);
        fl = 12'h004;
        take(-1);
        fl = 12'h804;
        take(8);
        chk(16'({in_high_service, in_low_service}), 16'h3);
        fl = '0;
        ret();
        ret();
        chk(16'({in_high_service, in_low_service}), 16'h0);
        global_interrupt_enable = 0;
        fl = 12'h002;
        take(-1);
        global_interrupt_enable = 1;
        source_enable = '0;
        take(-1);
        source_enable = '1;
        take(1);
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
